// ### design/regulator_fault_supervisor.sv
// Summary of operation
// R01 - ready held low while shut down; released after soft-start plus delay
// R02 - ready release delay is 85us after reference reaches target
// R03 - ready low on under/overvoltage, disable, power-on reset or off code
// R04 - undervoltage when sense is below half the coded voltage
// R05 - overvoltage protection armed from power-on reset, enabled or not
// R06 - trip level 1.273V until valid code, then reference plus 175mV
// R07 - overvoltage start drives all pwm outputs low within 20ns
// R08 - pwm high impedance below reference plus 75mV, low again on recurrence
// R09 - overvoltage stops switching until enable or supply reset, not code
// R10 - average current above 105uA triggers overcurrent shutdown
// R11 - current monitor above 1.11V triggers overcurrent shutdown
// R12 - overcurrent shutdown puts all pwm outputs high impedance within 20ns
// R13 - overcurrent off lasts 4096 switching cycles, then retry if enabled
// R14 - hiccup retries repeat until disabled or the fault clears
// R15 - phase over 129uA forces its pwm low for rest of cycle
// R16 - limited phase may resume next cycle; never shuts converter down
// R17 - thermal outputs open drain, valid only once enabled
// R18 - fan request below 39.1% of supply, cleared above 45.1%
// R19 - over temperature below 33.3% of supply, released at higher level
// R20 - off code after plateau shuts down until supply or enable recycle
// R21 - hiccup counter counts switching periods, restarts at each trip
// R22 - overvoltage beats overcurrent and blocks hiccup retry
`timescale 1ns/10ps
`default_nettype none

module regulator_fault_supervisor
  import fault_supervisor_pkg::*;
#(
  parameter int NUM_PHASES = PHASES,
  parameter int READY_DELAY = READY_RELEASE_DELAY_CYCLES,
  parameter int HICCUP_CYCLES = HICCUP_SWITCH_CYCLES
)
(
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic SUPPLY_OK,
  input wire logic BIAS_ENABLE_INPUT,
  input wire logic TERMINATION_RAIL_ENABLE,
  input wire logic SWITCH_TICK,
  input wire logic [NUM_PHASES-1:0] PWM_DEMAND,
  input wire logic [NUM_PHASES-1:0] PHASE_OVER,
  input wire sense_s SENSE,
  input wire sequence_s SEQUENCE,
  output logic [NUM_PHASES-1:0] PWM_OUT,
  output logic [NUM_PHASES-1:0] PWM_OE,
  output logic SOFTSTART_RUN,
  output logic OV_THRESHOLD_SELECT,
  output logic REGULATOR_READY_OUT,
  output logic REGULATOR_READY_OUT_OE,
  output logic FAN_REQUEST_OUT,
  output logic FAN_REQUEST_OUT_OE,
  output logic OVER_TEMPERATURE_OUT,
  output logic OVER_TEMPERATURE_OUT_OE,
  output logic OVERVOLTAGE_GUARD,
  output logic OVERCURRENT_OFF
);

  // states in which the converter may switch
  function automatic logic is_running(input state_e s);
    is_running = (s == ST_SOFTSTART) || (s == ST_SETTLE) ||
      (s == ST_READY);
  endfunction : is_running

  logic [PIN_COUNT-1:0] pin_meta;
  logic [PIN_COUNT-1:0] pin_sync;
  logic enabled;
  logic enabled_prev;
  logic enable_fell;
  logic supply_ok;
  state_e state;
  state_e next_state;
  logic [READY_COUNT_W-1:0] ready_count;
  logic [HICCUP_COUNT_W-1:0] hiccup_count;
  logic ready_delay_done;
  logic hiccup_done;
  logic overcurrent;
  logic ov_latched;
  logic ov_drive_low;
  logic ov_now;
  logic code_valid_seen;
  logic [NUM_PHASES-1:0] phase_limited;
  logic fan_flag;
  logic hot_flag;

  // two flip-flop synchronisers for the supply and enable pins
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      pin_meta <= PIN_SYNC_RESET;
      pin_sync <= PIN_SYNC_RESET;
    end
    else
    begin
      pin_meta <= {TERMINATION_RAIL_ENABLE, BIAS_ENABLE_INPUT, SUPPLY_OK};
      pin_sync <= pin_meta;
    end
  end

  assign supply_ok = pin_sync[PIN_SUPPLY];
  assign enabled = pin_sync[PIN_SUPPLY] & pin_sync[PIN_BIAS] &
    pin_sync[PIN_TERM];
  assign enable_fell = enabled_prev & ~enabled;
  assign overcurrent = SENSE.avg_over | SENSE.monitor_over; // see R10 R11
  // live overvoltage, only trusted while the supply is up
  assign ov_now = supply_ok & SENSE.ov_trip; // see R05
  assign ready_delay_done =
    (ready_count == READY_COUNT_W'(READY_DELAY - 1));
  assign hiccup_done =
    SWITCH_TICK && (hiccup_count == HICCUP_COUNT_W'(HICCUP_CYCLES - 1));

  // previous combined enable, for the falling edge
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
      enabled_prev <= 1'b0;
    else
      enabled_prev <= enabled;
  end

  // overvoltage latch: armed whenever supply is up, cleared by supply loss or a falling enable
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
      ov_latched <= 1'b0;
    else if (supply_ok && SENSE.ov_trip) // see R05
      ov_latched <= 1'b1;
    else if (!supply_ok || enable_fell) // see R09
      ov_latched <= 1'b0;
  end

  // crowbar low while over, release to high impedance below ref + 75mV
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
      ov_drive_low <= 1'b0;
    else if (supply_ok && SENSE.ov_trip) // see R07 R08
      ov_drive_low <= 1'b1;
    else if (!supply_ok || !ov_latched || SENSE.ov_below_release) // see R08
      ov_drive_low <= 1'b0;
  end

  // trip level stays at the fixed value until a valid code is seen
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
      code_valid_seen <= 1'b0;
    else if (state == ST_SOFTSTART && SEQUENCE.code_valid &&
      !SEQUENCE.code_off)
      code_valid_seen <= 1'b1; // see R06
    else if (!is_running(state))
      code_valid_seen <= 1'b0; // see R06
  end

  // sequencing: overvoltage outranks every other cause except loss of enable while running or in off code
  always_comb
  begin
    next_state = state;
    case (state)
      ST_SHUTDOWN:
        if (ov_latched || ov_now)
          next_state = ST_OV_LATCHED; // see R22
        else if (enabled)
          next_state = ST_SOFTSTART;
      ST_SOFTSTART, ST_SETTLE, ST_READY:
        if (!enabled)
          next_state = ST_SHUTDOWN; // see R03
        else if (ov_latched || (supply_ok && SENSE.ov_trip))
          next_state = ST_OV_LATCHED; // see R22
        else if (overcurrent)
          next_state = ST_HICCUP; // see R10 R11
        else if (state == ST_SOFTSTART && SEQUENCE.code_off)
          next_state = ST_CODE_OFF; // see R20
        else if (state == ST_SOFTSTART && SEQUENCE.at_target &&
          code_valid_seen)
          next_state = ST_SETTLE;
        else if (state == ST_SETTLE && ready_delay_done)
          next_state = ST_READY; // see R01 R02
      ST_HICCUP:
        if (ov_latched || ov_now)
          next_state = ST_OV_LATCHED; // see R22
        else if (!enabled)
          next_state = ST_SHUTDOWN; // see R14
        else if (hiccup_done)
          next_state = ST_SOFTSTART; // see R13 R14
      ST_OV_LATCHED:
        if (!ov_latched)
          next_state = ST_SHUTDOWN; // see R09
      ST_CODE_OFF:
        if (!enabled)
          next_state = ST_SHUTDOWN; // see R20
        else if (ov_latched)
          next_state = ST_OV_LATCHED;
      default:
        next_state = ST_SHUTDOWN;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
      state <= ST_SHUTDOWN;
    else
      state <= next_state;
  end

  // ready release delay, counted from reaching final target
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
      ready_count <= '0;
    else if (state != ST_SETTLE)
      ready_count <= '0;
    else if (!ready_delay_done)
      ready_count <= ready_count + 1'b1; // see R02
  end

  // hiccup wait, one step per switching period
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
      hiccup_count <= '0;
    else if (state != ST_HICCUP)
      hiccup_count <= '0; // see R21
    else if (SWITCH_TICK)
      hiccup_count <= hiccup_count + 1'b1; // see R13 R21
  end

  // per-phase limit: held until next cycle start if current is back down
  generate
    for (genvar i = 0; i < NUM_PHASES; i++)
    begin : g_phase
      always_ff @(posedge CLOCK or negedge RST_B)
      begin
        if (!RST_B)
          phase_limited[i] <= 1'b0;
        else if (PHASE_OVER[i])
          phase_limited[i] <= 1'b1; // see R15
        else if (SWITCH_TICK)
          phase_limited[i] <= 1'b0; // see R16
      end

      always_ff @(posedge CLOCK or negedge RST_B)
      begin
        if (!RST_B)
        begin
          PWM_OUT[i] <= 1'b0;
          PWM_OE[i] <= 1'b0;
        end
        // crowbar holds until sense drops below the release level
        else if (ov_now ||
          (supply_ok && ov_drive_low && !SENSE.ov_below_release))
        begin
          PWM_OUT[i] <= 1'b0; // see R07 R08
          PWM_OE[i] <= 1'b1;
        end
        else if (ov_latched || overcurrent || !is_running(next_state))
        begin
          PWM_OUT[i] <= 1'b0; // see R08 R12
          PWM_OE[i] <= 1'b0;
        end
        else
        begin
          PWM_OUT[i] <= PWM_DEMAND[i] & ~PHASE_OVER[i] &
            ~(phase_limited[i] & ~SWITCH_TICK); // see R15 R16
          PWM_OE[i] <= 1'b1;
        end
      end
    end
  endgenerate

  // thermal comparators with hysteresis
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      fan_flag <= 1'b0;
      hot_flag <= 1'b0;
    end
    else if (!enabled)
    begin
      fan_flag <= 1'b0; // see R17
      hot_flag <= 1'b0;
    end
    else
    begin
      if (SENSE.fan_set)
        fan_flag <= 1'b1; // see R18
      else if (SENSE.fan_clear)
        fan_flag <= 1'b0; // see R18
      if (SENSE.hot_set)
        hot_flag <= 1'b1; // see R19
      else if (SENSE.hot_clear)
        hot_flag <= 1'b0; // see R19
    end
  end

  // open-drain and status outputs, all registered
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      REGULATOR_READY_OUT <= 1'b0;
      REGULATOR_READY_OUT_OE <= 1'b1;
      FAN_REQUEST_OUT <= 1'b0;
      FAN_REQUEST_OUT_OE <= 1'b1;
      OVER_TEMPERATURE_OUT <= 1'b0;
      OVER_TEMPERATURE_OUT_OE <= 1'b1;
    end
    else
    begin
      REGULATOR_READY_OUT <= 1'b0;
      REGULATOR_READY_OUT_OE <= !(next_state == ST_READY &&
        !SENSE.under_voltage && !SENSE.ov_trip && !ov_latched &&
        enabled); // see R01 R03 R04
      FAN_REQUEST_OUT <= 1'b0;
      FAN_REQUEST_OUT_OE <= !fan_flag; // see R17 R18
      OVER_TEMPERATURE_OUT <= 1'b0;
      OVER_TEMPERATURE_OUT_OE <= !hot_flag; // see R17 R19
    end
  end

  // status levels for the sequencer and the system
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      SOFTSTART_RUN <= 1'b0;
      OV_THRESHOLD_SELECT <= 1'b0;
      OVERVOLTAGE_GUARD <= 1'b0;
      OVERCURRENT_OFF <= 1'b0;
    end
    else
    begin
      SOFTSTART_RUN <= is_running(next_state);
      OV_THRESHOLD_SELECT <= code_valid_seen && is_running(state); // see R06
      OVERVOLTAGE_GUARD <= ov_latched || (supply_ok && SENSE.ov_trip);
      OVERCURRENT_OFF <= (next_state == ST_HICCUP); // see R12
    end
  end

endmodule : regulator_fault_supervisor

`default_nettype wire

// ### design/fault_supervisor_pkg.sv
package fault_supervisor_pkg;

  // phase count of the controller
  localparam int PHASES = 4;

  // timing base
  localparam int CLOCK_PERIOD_PS = 10000;

  // delay from final target to ready release
  localparam int READY_RELEASE_DELAY_NS = 85000;
  localparam int READY_RELEASE_DELAY_CYCLES =
    (READY_RELEASE_DELAY_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

  // slowest allowed reaction of the pwm outputs to a fault
  localparam int FAULT_REACTION_NS = 20;
  localparam int FAULT_REACTION_CYCLES =
    (FAULT_REACTION_NS * 1000 / CLOCK_PERIOD_PS) < 1 ? 1 :
    (FAULT_REACTION_NS * 1000 / CLOCK_PERIOD_PS);

  // hiccup off time in switching cycles
  localparam int HICCUP_SWITCH_CYCLES = 4096;

  // counter widths
  localparam int READY_COUNT_W = 14;
  localparam int HICCUP_COUNT_W = 13;

  // pin synchroniser layout
  localparam int PIN_SUPPLY = 0;
  localparam int PIN_BIAS = 1;
  localparam int PIN_TERM = 2;
  localparam int PIN_COUNT = 3;

  // reset values
  localparam logic [2:0] PIN_SYNC_RESET = 3'h0;

  // supervisor states, gray along the start path
  typedef enum logic [2:0] {
    ST_SHUTDOWN = 3'h0,
    ST_SOFTSTART = 3'h1,
    ST_SETTLE = 3'h3,
    ST_READY = 3'h2,
    ST_HICCUP = 3'h6,
    ST_OV_LATCHED = 3'h7,
    ST_CODE_OFF = 3'h5
  } state_e;

  // comparator results from the sampled analog front end
  typedef struct packed {
    logic under_voltage;       // sense below half the coded voltage
    logic ov_trip;             // sense above selected trip level
    logic ov_below_release;    // differential sense below ref + 75mV
    logic avg_over;            // sensed average current above 105uA
    logic monitor_over;        // current monitor pin above 1.11V
    logic fan_set;             // temperature pin below 39.1% of supply
    logic fan_clear;           // temperature pin above 45.1% of supply
    logic hot_set;             // temperature pin below 33.3% of supply
    logic hot_clear;           // temperature pin above hot release level
  } sense_s;

  // soft-start sequencer status
  typedef struct packed {
    logic code_valid;          // valid voltage code read after plateau
    logic code_off;            // off code read after plateau
    logic at_target;           // reference reached final target
  } sequence_s;

endpackage : fault_supervisor_pkg

// ### bench/fault_supervisor_checker.sv
`timescale 1ns/10ps
`default_nettype none
module fault_supervisor_checker
  import fault_supervisor_pkg::*;
#(
  parameter int NUM_PHASES = PHASES,
  parameter int HICCUP_CYCLES = HICCUP_SWITCH_CYCLES
)
(
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic SUPPLY_OK,
  input wire logic BIAS_ENABLE_INPUT,
  input wire logic SWITCH_TICK,
  input wire logic [NUM_PHASES-1:0] PHASE_OVER,
  input wire sense_s SENSE,
  input wire logic [NUM_PHASES-1:0] PWM_OUT,
  input wire logic [NUM_PHASES-1:0] PWM_OE,
  input wire logic SOFTSTART_RUN,
  input wire logic REGULATOR_READY_OUT,
  input wire logic REGULATOR_READY_OUT_OE,
  input wire logic FAN_REQUEST_OUT_OE,
  input wire logic OVER_TEMPERATURE_OUT_OE,
  input wire logic OVERVOLTAGE_GUARD,
  input wire logic OVERCURRENT_OFF
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  logic [15:0] tick_cnt;
  // switching ticks seen during the hiccup off time
  always_ff @(posedge CLOCK or negedge RST_B)
    if (!RST_B)
      tick_cnt <= 16'h0;
    else if (!OVERCURRENT_OFF)
      tick_cnt <= 16'h0;
    else if (SWITCH_TICK)
      tick_cnt <= tick_cnt + 16'h1;
  AST_OV_LOW: assert property (SUPPLY_OK[*3] ##0 SENSE.ov_trip |=>
    PWM_OE == '1 && PWM_OUT == '0 && OVERVOLTAGE_GUARD)
    else $error("pwm not low on overvoltage");
  AST_OC_HIZ: assert property (OVERCURRENT_OFF |-> PWM_OE == '0
    && !SOFTSTART_RUN) else $error("pwm driven in hiccup");
  AST_OV_BLOCK: assert property (OVERVOLTAGE_GUARD |->
    !SOFTSTART_RUN) else $error("start while overvoltage");
  AST_OV_READY: assert property (OVERVOLTAGE_GUARD |->
    REGULATOR_READY_OUT_OE && !REGULATOR_READY_OUT)
    else $error("ready free in overvoltage");
  AST_UV_READY: assert property (SENSE.under_voltage |=>
    REGULATOR_READY_OUT_OE) else $error("ready free in undervoltage");
  AST_HICCUP_LEN: assert property ($fell(OVERCURRENT_OFF) &&
    SOFTSTART_RUN |-> tick_cnt inside {[HICCUP_CYCLES-1:HICCUP_CYCLES]})
    else $error("hiccup length wrong");
  AST_PHASE_LIMIT: assert property (1'b1 |=>
    (PWM_OUT & $past(PHASE_OVER)) == '0) else $error("phase not limited");
  AST_NO_LIMIT_SHUT: assert property ($rose(OVERCURRENT_OFF) |->
    $past(SENSE.avg_over) || $past(SENSE.monitor_over))
    else $error("shutdown without overcurrent");
  AST_THERM_OFF: assert property ((!BIAS_ENABLE_INPUT)[*5] |->
    FAN_REQUEST_OUT_OE && OVER_TEMPERATURE_OUT_OE)
    else $error("thermal flag while disabled");
  cover property ($rose(OVERCURRENT_OFF));
  cover property ($fell(REGULATOR_READY_OUT_OE));
  cover property ($rose(OVERVOLTAGE_GUARD));
endmodule : fault_supervisor_checker
bind regulator_fault_supervisor fault_supervisor_checker #(
  .NUM_PHASES(NUM_PHASES), .HICCUP_CYCLES(HICCUP_CYCLES)) checker_inst (
  .CLOCK, .RST_B, .SUPPLY_OK, .BIAS_ENABLE_INPUT, .SWITCH_TICK,
  .PHASE_OVER, .SENSE, .PWM_OUT, .PWM_OE, .SOFTSTART_RUN,
  .REGULATOR_READY_OUT, .REGULATOR_READY_OUT_OE, .FAN_REQUEST_OUT_OE,
  .OVER_TEMPERATURE_OUT_OE, .OVERVOLTAGE_GUARD, .OVERCURRENT_OFF);
`default_nettype wire

// ### bench/gate_driver_model.sv
`timescale 1ns/10ps
`default_nettype none
module gate_driver_model
  import fault_supervisor_pkg::*;
(
  input wire logic [PHASES-1:0] pwm_out,
  input wire logic [PHASES-1:0] pwm_oe,
  input wire logic rdy_out,
  input wire logic rdy_oe,
  input wire logic fan_out,
  input wire logic fan_oe,
  input wire logic hot_out,
  input wire logic hot_oe,
  output logic [PHASES-1:0] upper_on,
  output logic [PHASES-1:0] lower_on,
  output logic ready_pin,
  output logic fan_pin,
  output logic hot_pin
);
  // floating pwm input turns both transistors off
  assign upper_on = pwm_oe & pwm_out;
  assign lower_on = pwm_oe & ~pwm_out;
  // external pull-ups on the open-drain flags
  assign ready_pin = rdy_oe ? rdy_out : 1'b1;
  assign fan_pin = fan_oe ? fan_out : 1'b1;
  assign hot_pin = hot_oe ? hot_out : 1'b1;
endmodule : gate_driver_model
`default_nettype wire

// ### bench/regulator_fault_supervisor_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module regulator_fault_supervisor_tb_top
  import fault_supervisor_pkg::*;
;
  localparam int RD = 20;
  localparam int HC = 8;
  logic clock, rst_b, supply_ok, bias_en, term_en, tick;
  logic [3:0] dem, po, pwm_out, pwm_oe, upper_on, lower_on, hm;
  logic ss_run, ov_sel, rdy, rdy_oe, fan, fan_oe, hot, hot_oe, ovg, oco;
  logic ready_pin, fan_pin, hot_pin;
  sense_s sense;
  sequence_s seq;
  int failures, num_checks, n, seed;
  regulator_fault_supervisor #(.READY_DELAY(RD), .HICCUP_CYCLES(HC))
    regulator_fault_supervisor_inst (.CLOCK(clock), .RST_B(rst_b),
    .SUPPLY_OK(supply_ok), .BIAS_ENABLE_INPUT(bias_en),
    .TERMINATION_RAIL_ENABLE(term_en), .SWITCH_TICK(tick),
    .PWM_DEMAND(dem), .PHASE_OVER(po), .SENSE(sense), .SEQUENCE(seq),
    .PWM_OUT(pwm_out), .PWM_OE(pwm_oe), .SOFTSTART_RUN(ss_run),
    .OV_THRESHOLD_SELECT(ov_sel), .REGULATOR_READY_OUT(rdy),
    .REGULATOR_READY_OUT_OE(rdy_oe), .FAN_REQUEST_OUT(fan),
    .FAN_REQUEST_OUT_OE(fan_oe), .OVER_TEMPERATURE_OUT(hot),
    .OVER_TEMPERATURE_OUT_OE(hot_oe), .OVERVOLTAGE_GUARD(ovg),
    .OVERCURRENT_OFF(oco));
  gate_driver_model gate_driver_model_inst (.pwm_out(pwm_out),
    .pwm_oe(pwm_oe), .rdy_out(rdy), .rdy_oe(rdy_oe), .fan_out(fan),
    .fan_oe(fan_oe), .hot_out(hot), .hot_oe(hot_oe), .upper_on(upper_on),
    .lower_on(lower_on), .ready_pin(ready_pin), .fan_pin(fan_pin),
    .hot_pin(hot_pin));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  initial
  begin
    #900000;
    failures++;
    summarize();
  end
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask : cyc
  task automatic pulse();
    tick = 1'b1;
    cyc(1);
    tick = 1'b0;
    cyc(2);
  endtask : pulse
  task automatic wait_for(input logic v, input int sel, input int lim);
    n = 0;
    while ((sel == 0 ? ss_run : ready_pin) !== v)
    begin
      if (n == lim)
      begin
        failures++;
        summarize();
      end
      if (sel == 0)
        pulse();
      else
        cyc(1);
      n++;
    end
  endtask : wait_for
  // held limit mask after one edge
  function automatic logic [3:0] lim(logic [3:0] h, p, logic t);
    return t ? p : (h | p);
  endfunction : lim
  initial
  begin
    seed = 32'h1ca9;
    rst_b = 1'b0;
    supply_ok = 1'b1;
    bias_en = 1'b0;
    term_en = 1'b1;
    tick = 1'b0;
    dem = 4'h0;
    po = 4'h0;
    sense = '0;
    seq = '0;
    repeat (8) @(posedge clock);
    @(negedge clock) rst_b = 1'b1;
    cyc(3);
    chk(ready_pin === 1'b0, "ready off");
    bias_en = 1'b1;
    cyc(6);
    chk(ss_run === 1'b1 && ov_sel === 1'b0, "start");
    seq.code_valid = 1'b1;
    cyc(2);
    chk(ov_sel === 1'b1, "ov level");
    seq.at_target = 1'b1;
    wait_for(1'b1, 1, 200);
    chk(n >= RD && n <= RD + 3, "ready delay");
    sense.under_voltage = 1'b1;
    cyc(2);
    chk(ready_pin === 1'b0, "uv");
    sense.under_voltage = 1'b0;
    $display("test ready done");
    hm = 4'h0;
    repeat (40)
    begin
      dem = 4'($random(seed));
      po = 4'($random(seed) & $random(seed));
      tick = ($random(seed) & 3) == 0;
      cyc(1);
      hm = lim(hm, po, tick);
      chk(pwm_out === (dem & ~hm), "limit");
      chk(oco === 1'b0 && pwm_oe === 4'hf, "no shutdown");
    end
    po = 4'h0;
    tick = 1'b0;
    $display("test limit done");
    sense.fan_set = 1'b1;
    cyc(1);
    sense.fan_set = 1'b0;
    cyc(2);
    chk(fan_pin === 1'b1 && hot_pin === 1'b0, "fan");
    sense.hot_set = 1'b1;
    cyc(1);
    sense.hot_set = 1'b0;
    cyc(2);
    chk(hot_pin === 1'b1, "hot");
    sense.fan_clear = 1'b1;
    sense.hot_clear = 1'b1;
    cyc(1);
    sense = '0;
    cyc(2);
    chk(fan_pin === 1'b0 && hot_pin === 1'b0, "cool");
    $display("test thermal done");
    sense.avg_over = 1'b1;
    cyc(1);
    chk(oco === 1'b1 && (upper_on | lower_on) === 4'h0, "oc");
    sense.avg_over = 1'b0;
    wait_for(1'b1, 0, 60);
    chk(n == HC, "hiccup");
    sense.monitor_over = 1'b1;
    cyc(1);
    chk(oco === 1'b1, "current_monitor_out");
    repeat (HC) pulse();
    chk(oco === 1'b1 && ss_run === 1'b0, "retry");
    sense.monitor_over = 1'b0;
    wait_for(1'b1, 0, 60);
    chk(n == HC, "restart count");
    wait_for(1'b1, 1, 200);
    $display("test overcurrent done");
    sense.ov_trip = 1'b1;
    cyc(1);
    chk(lower_on === 4'hf && ready_pin === 1'b0, "ov");
    sense.ov_trip = 1'b0;
    sense.ov_below_release = 1'b1;
    cyc(1);
    chk((upper_on | lower_on) === 4'h0, "ov float");
    sense.ov_below_release = 1'b0;
    sense.ov_trip = 1'b1;
    cyc(1);
    chk(lower_on === 4'hf, "ov again");
    sense.ov_trip = 1'b0;
    seq = '0;
    sense.avg_over = 1'b1;
    repeat (HC + 2) pulse();
    chk(ovg === 1'b1 && ss_run === 1'b0, "ov latch");
    sense.avg_over = 1'b0;
    bias_en = 1'b0;
    sense.fan_set = 1'b1;
    cyc(5);
    chk(ovg === 1'b0 && fan_pin === 1'b0, "disable");
    sense = '0;
    sense.ov_trip = 1'b1;
    cyc(1);
    chk(ovg === 1'b1 && lower_on === 4'hf, "ov armed");
    sense.ov_trip = 1'b0;
    supply_ok = 1'b0;
    cyc(4);
    supply_ok = 1'b1;
    chk(ovg === 1'b0, "supply reset");
    $display("test overvoltage done");
    seq.code_off = 1'b1;
    bias_en = 1'b1;
    cyc(10);
    seq = '0;
    cyc(4);
    chk(ss_run === 1'b0 && ready_pin === 1'b0, "off code");
    bias_en = 1'b0;
    cyc(4);
    bias_en = 1'b1;
    cyc(6);
    chk(ss_run === 1'b1, "recycle");
    $display("test off code done");
    summarize();
  end
endmodule : regulator_fault_supervisor_tb_top
`default_nettype wire
